// [hw/lpsr_fifo.sv]
// small synchronous fifo between the parallel pins and the latch
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module lpsr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk_in,
    input  wire logic             rst_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
    logic             full, empty;

    ////////////////////////////////////////////////////////////////////////
    // extra pointer bit tells full from empty
    assign full          = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign empty         = (wr_q == rd_q);
    assign in_ready_out  = !full;
    assign out_valid_out = !empty;
    assign out_data_out  = mem[rd_q[AW-1:0]];

    always_comb begin
        wr_d = wr_q;
        rd_d = rd_q;
        if (in_valid_in && !full) begin
            wr_d = wr_q + 1'b1;
        end
        if (out_ready_in && !empty) begin
            rd_d = rd_q + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (in_valid_in && !full) begin
            mem[wr_q[AW-1:0]] <= in_data_in;
        end
        if (rst_in) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end
endmodule
`default_nettype wire

// [hw/lpsr_pkg.sv]
// types for the latched parallel-in serial-out shift register
// assumes lpsr_regs.svh is on the include path
`include "lpsr_regs.svh"
package lpsr_pkg;
    typedef logic [`LPSR_WIDTH-1:0] lpsr_byte_t;
    // synchronised pin levels
    typedef struct packed {
        logic latch_clk;
        logic shift_clk;
        logic mode;
        logic reset_n;
        logic serial;
    } lpsr_pins_t;
    // main state
    typedef struct packed {
        lpsr_pins_t s1;
        lpsr_pins_t s2;
        lpsr_pins_t prev;
        lpsr_byte_t par1;
        lpsr_byte_t par2;
        lpsr_byte_t latch;
        lpsr_byte_t sreg;
        logic       pend;
        logic       ser_out;
        logic       stall;
    } lpsr_state_t;
    // fifo state
    typedef struct packed {
        logic [3:0] wr;
        logic [3:0] rd;
    } lpsr_fifo_t;
endpackage

// [hw/lpsr_regs.svh]
// constants for the latched parallel-in serial-out shift register
// assumes inclusion from the package and design modules by bare name
`ifndef LPSR_REGS_SVH
`define LPSR_REGS_SVH
`define LPSR_WIDTH        8
`define LPSR_FIFO_DEPTH   8
`define LPSR_SR_RESET     8'h00
`define LPSR_LATCH_RESET  8'h00
`define LPSR_LAST_BIT     7
`endif

// [hw/lpsr_top.sv]
// latched parallel-in serial-out shift register, sampled pin model
// assumes all pins asynchronous to sys_clk_in, which is much faster
// Functional notes
// - latch clock rising edge captures the eight parallel inputs; held until next edge
// - mode high: shift clock rising edge moves serial input into first stage
// - mode low: serial input is ignored by every shift clock edge
// - mode high puts the shift register in serial shifting mode
// - mode low loads latch into shift register and blocks shifting
// - reset low clears all shift stages to zero without waiting for clocks
// - reset leaves the latch alone; latch still captures during reset
// - each shift edge moves every stage to the next; last feeds the output
// - serial output always shows the last stage
// - reset high, mode low: latch passes to shift register, last bit out
// - mode low: latch clock edge loads latch and shift register together
`timescale 1ns/10ps
`default_nettype none
`include "lpsr_regs.svh"
module lpsr_top (
    input  wire logic                  sys_clk_in,
    input  wire logic                  rst_in,
    input  wire logic [`LPSR_WIDTH-1:0] par_data_in,
    input  wire logic                  serial_in,
    input  wire logic                  latch_clk_in,
    input  wire logic                  shift_clk_in,
    input  wire logic                  shift_mode_in,
    input  wire logic                  sr_reset_n_in,
    output logic                       serial_out,
    output logic                       capture_stall_out
);
    lpsr_pkg::lpsr_state_t st_q, st_d;
    lpsr_pkg::lpsr_pins_t  pins;
    logic                  fifo_ready, fifo_valid, pop;
    lpsr_pkg::lpsr_byte_t  fifo_data;

    // shift one place toward the output, new bit into stage 0
    function automatic lpsr_pkg::lpsr_byte_t shift_in(lpsr_pkg::lpsr_byte_t v, logic b);
        shift_in = {v[`LPSR_WIDTH-2:0], b};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin bundle feeding the two-flop synchroniser
    assign pins = '{latch_clk: latch_clk_in, shift_clk: shift_clk_in,
                    mode: shift_mode_in, reset_n: sr_reset_n_in, serial: serial_in};

    // captured bytes queue here so a late latch update never loses a word
    lpsr_fifo #(
        .WIDTH (`LPSR_WIDTH),
        .DEPTH (`LPSR_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_in    (sys_clk_in),
        .rst_in        (rst_in),
        .in_valid_in   (st_q.pend),
        .in_ready_out  (fifo_ready),
        .in_data_in    (st_q.par2),
        .out_valid_out (fifo_valid),
        .out_ready_in  (pop),
        .out_data_out  (fifo_data)
    );
    assign pop = fifo_valid;

    ////////////////////////////////////////////////////////////////////////
    // next state; only s2 and prev are looked at, never s1
    always_comb begin
        st_d         = st_q;
        st_d.s1      = pins;
        st_d.s2      = st_q.s1;
        st_d.par1    = par_data_in;
        st_d.par2    = st_q.par1;
        st_d.prev    = st_q.s2;
        if (st_q.pend && fifo_ready) begin
            st_d.pend = 1'b0;
        end
        // latch edge queued even while the shift reset is low
        if (st_q.s2.latch_clk && !st_q.prev.latch_clk) begin
            st_d.pend = 1'b1;
        end
        // freeze the word seen with the edge until the queue takes it, so data
        // that moves right after the latch edge is never captured instead
        if (st_d.pend) begin
            st_d.par2 = st_q.par2;
        end
        if (pop) begin
            st_d.latch = fifo_data;
        end
        if (!st_q.s2.reset_n) begin
            st_d.sreg = `LPSR_SR_RESET;
        end else if (!st_q.s2.mode) begin
            // transparent load follows latch, including a fresh capture
            st_d.sreg = pop ? fifo_data : st_q.latch;
        end else if (st_q.s2.shift_clk && !st_q.prev.shift_clk) begin
            st_d.sreg = shift_in(st_q.sreg, st_q.s2.serial);
        end
        st_d.ser_out = st_d.sreg[`LPSR_LAST_BIT];
        st_d.stall   = st_d.pend && !fifo_ready;
    end

    // reset gives a known image; the latch is only cleared by system reset
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            st_q       <= '0;
            st_q.latch <= `LPSR_LATCH_RESET;
            st_q.sreg  <= `LPSR_SR_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign serial_out        = st_q.ser_out;
    assign capture_stall_out = st_q.stall;
endmodule
`default_nettype wire

// [testbench/lpsr_host.sv]
// host model: one frame of eight 800 ns shift clocks, msb first
// assumes go_in is pulsed for one cycle while idle
`timescale 1ns/10ps
`default_nettype none
module lpsr_host (
    input wire logic       sys_clk_in,
    input wire logic       rst_in,
    input wire logic       go_in,
    input wire logic [7:0] tx_in,
    input wire logic       rx_bit_in,
    output logic           shift_clk_out,
    output logic           data_out,
    output logic           busy_out,
    output logic     [7:0] rx_out
);
    logic [5:0] cnt_q;
    // clock stands low between frames
    assign shift_clk_out = busy_out & cnt_q[2];
    // data moves three system clocks before each rise, read just before it
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            busy_out <= 1'h0;
            cnt_q <= 6'h00;
            data_out <= 1'h0;
        end else if (busy_out) begin
            cnt_q <= cnt_q + 6'h01;
            busy_out <= cnt_q != 6'h3f;
            if (cnt_q[2:0] == 3'h0) data_out <= tx_in[3'h7 - cnt_q[5:3]];
            if (cnt_q[2:0] == 3'h3) rx_out <= {rx_out[6:0], rx_bit_in};
            if (cnt_q == 6'h3f) data_out <= ~data_out; // released line must not look held
        end else busy_out <= go_in;
    end
endmodule
`default_nettype wire

// [testbench/lpsr_props.sv]
// checker on the pins of lpsr_top
// assumes every pin is held at least three system clocks
`timescale 1ns/10ps
`default_nettype none
module lpsr_props (
    input wire logic       sys_clk_in,
    input wire logic       rst_in,
    input wire logic [7:0] par_data_in,
    input wire logic       serial_in,
    input wire logic       latch_clk_in,
    input wire logic       shift_clk_in,
    input wire logic       shift_mode_in,
    input wire logic       sr_reset_n_in,
    input wire logic       serial_out,
    input wire logic       capture_stall_out
);
    logic       b7_q;
    logic [3:0] quiet_q;
    wire        ld = !shift_mode_in && sr_reset_n_in && !latch_clk_in;
    // latched msb, and cycles since a control pin moved (pins are sampled late)
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) b7_q <= 1'h0;
        else if ($rose(latch_clk_in)) b7_q <= par_data_in[7];
        if (rst_in || $changed({latch_clk_in, shift_clk_in, shift_mode_in, sr_reset_n_in}))
            quiet_q <= 4'h0;
        else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    chk_clear_hold: assert property (!sr_reset_n_in [*6] |-> !serial_out)
        else $error("out not cleared");
    chk_clear_fast: assert property ($fell(sr_reset_n_in) |-> ##[1:6] !serial_out)
        else $error("clear too slow");
    chk_out_quiet: assert property (quiet_q >= 4'h8 |-> $stable(serial_out))
        else $error("out moved without cause");
    chk_latch_out: assert property (ld [*8] |-> serial_out == b7_q)
        else $error("load msb wrong");
    chk_edge_load: assert property ($rose(latch_clk_in) && !shift_mode_in ##1
        (!shift_mode_in && sr_reset_n_in) [*8] |-> serial_out == $past(par_data_in[7], 8))
        else $error("edge load wrong");
    chk_no_shift: assert property (ld [*6] ##1 (ld && $rose(shift_clk_in)) ##1 ld [*6]
        |-> $stable(serial_out)) else $error("shifted in load mode");
    chk_shift_lat: assert property ((shift_mode_in && sr_reset_n_in) [*8]
        ##1 $rose(shift_clk_in) |-> $stable(serial_out) [*3]) else $error("shift too early");
    chk_no_stall: assert property (!capture_stall_out) else $error("capture stalled");
    cov_shift: cover property ($rose(shift_clk_in) && shift_mode_in);
    cov_load: cover property ($rose(latch_clk_in) && !shift_mode_in);
    cov_clear: cover property ($fell(sr_reset_n_in));
endmodule
bind lpsr_top lpsr_props chk_u (.*);
`default_nettype wire

// [testbench/lpsr_top_tb.sv]
// bench for lpsr_top with the host model on the serial side
// assumes lpsr_host drives shift clock and serial data
`timescale 1ns/10ps
`default_nettype none
module lpsr_top_tb;
    logic clk = 1'h0, rst = 1'h1, lclk = 1'h0, mode = 1'h0, rn = 1'h1, go = 1'h0;
    logic [7:0] par = 8'h00, tx = 8'h00, rx;
    logic sclk, sdat, sout, busy;
    int n_fail = 0, total_checks = 0;
    lpsr_top dut_u (.sys_clk_in(clk), .rst_in(rst), .par_data_in(par), .serial_in(sdat),
        .latch_clk_in(lclk), .shift_clk_in(sclk), .shift_mode_in(mode),
        .sr_reset_n_in(rn), .serial_out(sout), .capture_stall_out());
    lpsr_host host_u (.sys_clk_in(clk), .rst_in(rst), .go_in(go), .tx_in(tx),
        .rx_bit_in(sout), .shift_clk_out(sclk), .data_out(sdat), .busy_out(busy), .rx_out(rx));
    initial forever #50 clk = ~clk;
    task automatic wt(input int n); repeat (n) @(posedge clk); endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    // one host frame; busy checked at a falling edge, then eight rising edges before the caller reads rx
    task automatic frame(input logic [7:0] t);
        wt(1); tx <= t; go <= 1'h1; wt(1); go <= 1'h0; wt(1);
        for (int i = 0; i < 80 && busy; i++) @(negedge clk);
        chk("frame done", 8'h00, {7'h00, busy});
        wt(8);
    endtask
    task automatic latch(input logic [7:0] d);
        wt(1); par <= d; wt(2); lclk <= 1'h1; wt(4); lclk <= 1'h0; wt(10);
    endtask
    task automatic t_load_shift();
        latch(8'h96);
        @(negedge clk) chk("load msb", 8'h01, {7'h00, sout});
        wt(1); mode <= 1'h1; wt(4);
        frame(8'ha5); chk("read byte", 8'h96, rx);
        frame(8'h3c); chk("shift in", 8'ha5, rx);
    endtask
    task automatic t_mode_low();
        wt(1); mode <= 1'h0; wt(10);
        frame(8'h00); chk("no shift", 8'hff, rx);
    endtask
    task automatic t_reset();
        wt(1); mode <= 1'h1; wt(8); rn <= 1'h0; wt(6);
        @(negedge clk) chk("cleared", 8'h00, {7'h00, sout});
        wt(1); mode <= 1'h0; wt(10);
        @(negedge clk) chk("clear over load", 8'h00, {7'h00, sout});
        wt(1); rn <= 1'h1; wt(10);
        @(negedge clk) chk("kept msb", 8'h01, {7'h00, sout});
        wt(1); rn <= 1'h0; mode <= 1'h1;
        latch(8'h5a); rn <= 1'h1; mode <= 1'h0; wt(12);
        wt(1); mode <= 1'h1; frame(8'h00); chk("latch in reset", 8'h5a, rx);
    endtask
    task automatic final_report();
        if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        wt(12); rst <= 1'h0; t_load_shift(); t_mode_low(); t_reset(); final_report();
    end
    // the run needs well under 1000 cycles
    initial begin
        wt(5000); n_fail++; final_report();
    end
endmodule
`default_nettype wire
